// ### dv/twc_slave_model.sv
// Bus-side slave model: acks its address, keeps the last written byte, sends i_tx then its inverse on reads.
// Assumes open-drain lines with pull-ups resolved by the bench.
`timescale 1ns/100ps
`default_nettype none
module twc_slave_model #(parameter logic [6:0] ADDR = 7'h2a) (
  input wire logic i_mclk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_tx,
  input wire logic [3:0] i_stretch,
  output logic o_scl_rel,
  output logic o_sda_rel,
  output logic [7:0] o_last,
  output logic o_stop
);
  logic scl_q, sda_q, first, sel, rdm;
  logic [3:0] bitc, hold;
  logic [7:0] sh, tx;
  initial begin
    {scl_q, sda_q, o_scl_rel, o_sda_rel} = 4'hf;
    {first, sel, rdm, o_stop, bitc, hold, sh, tx, o_last} = '0;
  end
  always @(posedge i_mclk) begin
    scl_q <= i_scl;
    sda_q <= i_sda;
    if (hold != 4'h0) begin
      hold <= hold - 4'h1;
      o_scl_rel <= (hold == 4'h1);
    end
    if (scl_q && i_scl && sda_q && !i_sda) begin
      bitc <= 4'h0;
      first <= 1'b1;
      o_stop <= 1'b0;
    end else if (scl_q && i_scl && !sda_q && i_sda) begin
      {sel, rdm} <= 2'h0;
      o_stop <= 1'b1;
      o_sda_rel <= 1'b1;
    end else if (!scl_q && i_scl) begin
      sh <= {sh[6:0], i_sda};
      bitc <= bitc + 4'h1;
      if (bitc == 4'h8 && rdm && i_sda) rdm <= 1'b0;
    end else if (scl_q && !i_scl) begin
      if (i_stretch != 4'h0) begin
        o_scl_rel <= 1'b0;
        hold <= i_stretch;
      end
      if (bitc == 4'h8) begin
        if (first) sel <= (sh[7:1] == ADDR);
        if (first) rdm <= (sh[7:1] == ADDR) && sh[0];
        if (!first && sel && !rdm) o_last <= sh;
        tx <= first ? i_tx : ~tx;
        o_sda_rel <= !(first ? sh[7:1] == ADDR : sel && !rdm);
      end else if (bitc == 4'h9 || (rdm && !first && bitc != 4'h0)) begin
        o_sda_rel <= !rdm | tx[7];
        tx <= {tx[6:0], tx[7]};
        if (bitc == 4'h9) bitc <= 4'h0;
        if (bitc == 4'h9) first <= 1'b0;
      end
    end
  end
endmodule : twc_slave_model
`default_nettype wire

// ### dv/two_wire_serial_control_regs_tb.sv
// Self-checking bench: registers, master write and read, receive buffer, disable.
// Assumes the slave model on open-drain lines with pull-ups.
`timescale 1ns/100ps
`default_nettype none
module two_wire_serial_control_regs_tb
  import twc_pkg::*;
;
  logic clk, rstn, wr, gie, rdy, irq, scl_oe_n, sda_oe_n, rxv, scl_rel, sda_rel, stp;
  logic [2:0] addr;
  logic [3:0] stretch;
  logic [7:0] wdata, rdata, rxd, last, tx0, r, v;
  logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'hf8, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00};
  logic [7:0] sla [3] = '{8'h56, 8'h54, 8'h55};
  logic [4:0] slsc [3] = '{SC_SLAW_NACK, SC_SLAW_ACK, SC_SLAR_ACK};
  int n_fail = 0;
  int cmp_count = 0;
  wire logic scl_w = scl_oe_n & scl_rel;
  wire logic sda_w = sda_oe_n & sda_rel;
  twc_controller twc_controller_i (.i_mclk(clk), .i_resetn(rstn), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_global_irq_en(gie), .o_irq(irq), .i_scl(scl_w),
    .o_scl(), .o_scl_oe_n(scl_oe_n), .i_sda(sda_w), .o_sda(), .o_sda_oe_n(sda_oe_n),
    .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rdy));
  twc_slave_model twc_slave_model_i (.i_mclk(clk), .i_scl(scl_w), .i_sda(sda_w), .i_tx(tx0),
    .i_stretch(stretch), .o_scl_rel(scl_rel), .o_sda_rel(sda_rel), .o_last(last), .o_stop(stp));
  always #20 clk = ~clk;
  task automatic end_sim();
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdr(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    @(posedge clk);
    #1 d = rdata;
  endtask : rdr
  task automatic poll(input int bitn, input logic want);
    v = {8{!want}};
    for (int i = 0; i < 3000 && v[bitn] !== want; i++) rdr(ADDR_CTRL, v);
    chk("control poll", {7'h00, want}, {7'h00, v[bitn]});
    if (v[bitn] !== want) end_sim();
  endtask : poll
  task automatic step(input logic [7:0] c, input logic [4:0] sc);
    wrr(ADDR_CTRL, c);
    poll(CTRL_FLAG, 1'b1);
    rdr(ADDR_STAT, v);
    chk("status", {sc, 3'h0}, v & 8'hf8);
    chk("scl hold", 8'h00, {7'h00, scl_oe_n});
  endtask : step
  initial begin
    {clk, rstn, wr, rdy, addr, wdata, stretch} = '0;
    gie = 1'b1;
    void'($urandom(32'h9f451b0e));
    tx0 = 8'($urandom);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdr(3'(i), v);
      chk("reset value", rst_exp[i], v);
    end
    repeat (4) begin
      r = 8'($urandom);
      wrr(ADDR_BR, r);
      rdr(ADDR_BR, v);
      chk("divider", r, v);
      wrr(ADDR_STAT, r);
      rdr(ADDR_STAT, v);
      chk("prescale", {SC_NOINFO, 1'b0, r[1:0]}, v);
      wrr(ADDR_MASK, r);
      rdr(ADDR_MASK, v);
      chk("mask", {r[7:1], 1'b0}, v);
      wrr(ADDR_OWN, r);
      rdr(ADDR_OWN, v);
      chk("own address", r, v);
      wrr(ADDR_DATA, r);
      rdr(ADDR_DATA, v);
      chk("data", 8'hff, v);
      wrr(ADDR_CTRL, r & 8'h4b);
      rdr(ADDR_CTRL, v);
      chk("control", (r & 8'h41) | 8'h08, v);
    end
    wrr(ADDR_OWN, 8'hfe);
    wrr(ADDR_BR, 8'h0a);
    wrr(ADDR_STAT, 8'h00);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) stretch <= 4'(k * 3);
      step(8'ha5, SC_START);
      chk("irq", 8'h01, {7'h00, irq});
      @(posedge clk) gie <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("irq", 8'h00, {7'h00, irq});
      @(posedge clk) gie <= 1'b1;
      wrr(ADDR_DATA, sla[k]);
      rdr(ADDR_CTRL, v);
      chk("collision", 8'h00, v & 8'h08);
      step(8'h85, slsc[k]);
      if (k == 1) begin
        r = 8'($urandom);
        wrr(ADDR_DATA, r);
        step(8'h85, SC_MT_ACK);
        chk("slave byte", r, last);
      end
      if (k == 2) begin
        step(8'hc5, SC_MR_ACK);
        step(8'h85, SC_MR_NACK);
      end
      wrr(ADDR_CTRL, 8'h95);
      poll(CTRL_STO, 1'b0);
      chk("stop seen", 8'h01, {7'h00, stp});
      chk("lines", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    end
    rdr(ADDR_DATA, v);
    chk("data", ~tx0, v);
    chk("rx head", tx0, rxv ? rxd : ~tx0);
    @(posedge clk) rdy <= 1'b1;
    @(posedge clk) rdy <= 1'b0;
    #1 chk("rx next", ~tx0, rxv ? rxd : tx0);
    @(posedge clk) rdy <= 1'b1;
    @(posedge clk) rdy <= 1'b0;
    #1 chk("rx valid", 8'h00, {7'h00, rxv});
    step(8'ha4, SC_START);
    wrr(ADDR_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk("disabled lines", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    end_sim();
  end
endmodule : two_wire_serial_control_regs_tb
`default_nettype wire

// ### rtl/twc_controller.sv
// Two-wire serial controller: register file, bit engine, address match and receive buffer.
// Assumes open-drain SCL/SDA pads outside and a CPU register port on the same clock.
//
// Operation
// - Bit-rate divider register sets the master serial clock division factor.
// - Event flag, control bit 7, sets when a job ends and needs software.
// - Interrupt asserts while flag, interrupt enable and global enable are all high.
// - Serial clock held low while the event flag is set and the controller is enabled.
// - Software clears the flag by writing one; no automatic clear.
// - Clearing the flag launches the next operation; finish register accesses first.
// - With ack enable, acknowledge own address, enabled general call, received data.
// - Ack enable low: no acknowledge, no address recognition until set again.
// - Start request makes a START when free, else after the next STOP.
// - Master stop request makes a STOP, then clears itself.
// - Slave stop request: return unaddressed, release both lines.
// - Data write with flag low sets collision; with flag high clears it.
// - Enable hands pins to controller; disable ends any transfer at once.
// - Control bit 1 always reads zero.
// - Status register shows 5-bit status code in bits 7..3 with prescaler.
// - Prescaler field picks 1, 4, 16 or 64; status bit 2 reads zero.
// - Data register writable and stable only while the flag is set.
// - Bus data shifts into data register; arbitration loss loses no data.
// - Own address in bits 7..1 compared against received slave addresses.
// - Address bit 0 enables general call 0x00; a match raises the flag.
// - Set mask bits exclude own-address bits from comparison; mask bit 0 reads zero.
// - Master SCL rate is clock over 16 plus 2 times divider times 4^prescale.
// - Status code loads one cycle after the flag; otherwise no-information code.
`timescale 1ns/100ps
`default_nettype none

module twc_controller
  import twc_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [2:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  input wire logic i_global_irq_en,
  output logic o_irq,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe_n,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready
);

  twc_state_t s;
  twc_state_t n;
  logic ev_set;

  assign o_reg_rdata = s.rdata;
  assign o_irq = s.irq;
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe_n = s.scl_oe_n;
  assign o_sda_oe_n = s.sda_oe_n;
  assign o_rx_valid = s.rxv;
  assign o_rx_data = s.q0;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [14:0] half;
    logic scl;
    logic sda;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic match;
    logic gcm;
    logic rxop;
    logic push;
    logic scl_pull;
    half = '0;
    scl = 1'b0;
    sda = 1'b0;
    start_det = 1'b0;
    stop_det = 1'b0;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    match = 1'b0;
    gcm = 1'b0;
    rxop = 1'b0;
    push = 1'b0;
    scl_pull = 1'b0;
    ev_set = 1'b0;
    n = s;
    // Half an SCL period; the full period is 16 + 2*divider*4^prescale.
    half = HALF_BASE + (15'(s.br) << {s.ps, 1'b0});
    n.scl_sy = {s.scl_sy[0], i_scl};
    n.sda_sy = {s.sda_sy[0], i_sda};
    scl = s.scl_sy[1];
    sda = s.sda_sy[1];
    n.scl_d = scl;
    n.sda_d = sda;
    start_det = scl && s.scl_d && s.sda_d && !sda;
    stop_det = scl && s.scl_d && !s.sda_d && sda;
    scl_rise = scl && !s.scl_d;
    scl_fall = !scl && s.scl_d;
    if (start_det) begin
      n.busy = 1'b1;
    end
    if (stop_det) begin
      n.busy = 1'b0;
    end
    if (s.cnt != '0) begin
      n.cnt = s.cnt - 15'h0001;
    end
    if (i_rx_ready && s.qcnt != '0) begin
      n.q0 = s.q1;
      n.qcnt = s.qcnt - 2'h1;
    end

    case (s.st)
      ST_IDLE: begin
        if (s.en && s.sta && !s.flag) begin
          if (!s.busy) begin
            n.st = ST_START;
            n.cnt = half;
            n.sda_drv = 1'b1;
            n.master = 1'b1;
            n.rs = 1'b0;
          end
        end else if (s.en && start_det && s.ack_en) begin
          n.st = ST_SLAVE;
          n.bitn = '0;
          n.addr_ph = 1'b1;
          n.tx = 1'b0;
        end
      end
      ST_START: begin
        if (s.cnt == '0) begin
          n.st = ST_HOLD;
          n.tx = 1'b1;
          n.addr_ph = 1'b1;
          n.pend = s.rs ? SC_RSTART : SC_START;
          ev_set = 1'b1;
        end
      end
      ST_LOW: begin
        if (s.cnt == '0) begin
          n.st = ST_HIGH;
          n.cnt = half;
        end
      end
      ST_HIGH: begin
        if (!scl) begin
          n.cnt = half;
        end else if (s.cnt == '0) begin
          if (s.bitn < ACK_BIT) begin
            n.data = {s.data[6:0], sda};
            if (s.tx && !s.sda_drv && !sda) begin
              // Lost arbitration: keep the shifted byte and continue as a listener.
              n.master = 1'b0;
              n.arb = 1'b1;
              n.sda_drv = 1'b0;
              n.st = ST_SLAVE;
            end else begin
              n.bitn = s.bitn + 4'h1;
              n.st = ST_LOW;
              n.cnt = half;
              if (s.bitn == 4'h7) begin
                n.sda_drv = !s.tx && s.ack_en;
              end else begin
                n.sda_drv = s.tx && !s.data[6];
              end
            end
          end else begin
            n.rx_ack = !sda;
            n.sda_drv = 1'b0;
            n.st = ST_HOLD;
            ev_set = 1'b1;
            if (s.addr_ph) begin
              n.addr_ph = 1'b0;
              n.tx = !s.data[0];
              if (s.data[0]) begin
                n.pend = !sda ? SC_SLAR_ACK : SC_SLAR_NACK;
              end else begin
                n.pend = !sda ? SC_SLAW_ACK : SC_SLAW_NACK;
              end
            end else if (s.tx) begin
              n.pend = !sda ? SC_MT_ACK : SC_MT_NACK;
            end else begin
              n.pend = !sda ? SC_MR_ACK : SC_MR_NACK;
              push = 1'b1;
            end
          end
        end
      end
      ST_HOLD: begin
        rxop = !s.sta && !s.sto && !s.tx && !s.addr_ph && (s.master || s.addressed);
        // A receive waits here, clock held low, until the buffer has room.
        if (s.go && !s.flag && !(rxop && s.qcnt == FIFO_DEPTH)) begin
          n.go = 1'b0;
          n.bitn = '0;
          n.cnt = half;
          if (s.sta && s.master) begin
            n.st = ST_PRE_LOW;
            n.stopping = 1'b0;
          end else if (s.sta) begin
            n.addressed = 1'b0;
            n.st = ST_IDLE;
          end else if (s.sto && s.master) begin
            n.st = ST_PRE_LOW;
            n.stopping = 1'b1;
          end else if (s.sto) begin
            n.addressed = 1'b0;
            n.sda_drv = 1'b0;
            n.sto = 1'b0;
            n.st = ST_IDLE;
          end else if (s.master || s.addressed) begin
            n.st = s.master ? ST_LOW : ST_SLAVE;
            n.sda_drv = s.tx && !s.data[7];
          end else begin
            n.st = ST_IDLE;
          end
        end
      end
      ST_PRE_LOW: begin
        n.sda_drv = s.stopping;
        if (s.cnt == '0) begin
          n.st = ST_PRE_HIGH;
          n.cnt = half;
        end
      end
      ST_PRE_HIGH: begin
        if (!scl) begin
          n.cnt = half;
        end else if (s.cnt == '0) begin
          n.cnt = half;
          if (s.stopping) begin
            n.sda_drv = 1'b0;
            n.master = 1'b0;
            n.sto = 1'b0;
            n.st = ST_IDLE;
          end else begin
            n.sda_drv = 1'b1;
            n.rs = 1'b1;
            n.st = ST_START;
          end
        end
      end
      ST_SLAVE: begin
        if (stop_det) begin
          n.sda_drv = 1'b0;
          n.addressed = 1'b0;
          n.arb = 1'b0;
          n.st = ST_IDLE;
          if (s.addressed && !s.addr_ph) begin
            n.st = ST_HOLD;
            n.pend = SC_SL_STOP;
            ev_set = 1'b1;
          end
        end else if (start_det) begin
          n.bitn = '0;
          n.addr_ph = 1'b1;
          n.addressed = 1'b0;
          n.tx = 1'b0;
          n.sda_drv = 1'b0;
        end else if (scl_rise) begin
          if (s.bitn < ACK_BIT) begin
            n.data = {s.data[6:0], sda};
          end else begin
            n.rx_ack = !sda;
          end
        end else if (scl_fall) begin
          if (s.bitn < 4'h7) begin
            n.bitn = s.bitn + 4'h1;
            n.sda_drv = s.tx && !s.data[7];
          end else if (s.bitn == 4'h7) begin
            n.bitn = ACK_BIT;
            n.sda_drv = 1'b0;
            if (s.addr_ph) begin
              match = ((s.data[7:1] ^ s.own[7:1]) & ~s.mask) == 7'h00;
              gcm = s.data[7:1] == 7'h00 && s.own[0];
              if ((match || gcm) && s.ack_en) begin
                n.addressed = 1'b1;
                n.gc = gcm;
                n.tx = s.data[0] && !gcm;
                n.sda_drv = 1'b1;
              end else if (!s.arb) begin
                n.st = ST_IDLE;
              end
            end else if (!s.tx) begin
              n.sda_drv = s.ack_en;
            end
          end else begin
            n.bitn = '0;
            n.sda_drv = 1'b0;
            n.addr_ph = 1'b0;
            n.arb = 1'b0;
            if (s.addressed || s.arb) begin
              n.st = ST_HOLD;
              ev_set = 1'b1;
              if (s.addr_ph && s.addressed) begin
                n.pend = s.gc ? SC_SR_GC : (s.tx ? SC_ST_ADDR : SC_SR_ADDR);
              end else if (!s.addressed) begin
                n.pend = SC_ARB;
              end else if (s.tx) begin
                n.pend = s.rx_ack ? SC_ST_ACK : SC_ST_NACK;
                n.addressed = s.rx_ack;
              end else begin
                n.pend = s.ack_en ? SC_SR_ACK : SC_SR_NACK;
                n.addressed = s.ack_en;
                push = 1'b1;
              end
            end else begin
              n.st = ST_IDLE;
            end
          end
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    if (push) begin
      if (n.qcnt == '0) begin
        n.q0 = s.data;
      end else begin
        n.q1 = s.data;
      end
      n.qcnt = n.qcnt + 2'h1;
    end

    // Register writes come after the engine so a software set of stop wins over its clear.
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_BR: n.br = i_reg_wdata;
        ADDR_CTRL: begin
          n.ack_en = i_reg_wdata[CTRL_ACK];
          n.sta = i_reg_wdata[CTRL_STA];
          n.sto = i_reg_wdata[CTRL_STO];
          n.en = i_reg_wdata[CTRL_EN];
          n.ie = i_reg_wdata[CTRL_IE];
          if (i_reg_wdata[CTRL_FLAG] && s.flag) begin
            n.flag = 1'b0;
            n.go = 1'b1;
          end
        end
        ADDR_STAT: n.ps = i_reg_wdata[1:0];
        ADDR_DATA: begin
          if (s.flag) begin
            n.data = i_reg_wdata;
            n.wc = 1'b0;
          end else begin
            n.wc = 1'b1;
          end
        end
        ADDR_OWN: n.own = i_reg_wdata;
        ADDR_MASK: n.mask = i_reg_wdata[7:1];
        default: begin
        end
      endcase
    end

    if (!n.en) begin
      n.st = ST_IDLE;
      n.master = 1'b0;
      n.addressed = 1'b0;
      n.sda_drv = 1'b0;
      n.go = 1'b0;
      n.arb = 1'b0;
      n.addr_ph = 1'b0;
    end
    if (ev_set) begin
      n.flag = 1'b1;
    end

    n.status = s.flag ? s.pend : SC_NOINFO;
    scl_pull = n.flag || n.st == ST_LOW || n.st == ST_PRE_LOW || (n.st == ST_HOLD && (n.master || n.addressed));
    n.scl_oe_n = !(n.en && scl_pull);
    n.sda_oe_n = !(n.en && n.sda_drv);
    n.irq = n.flag && n.ie && i_global_irq_en;
    n.rxv = n.qcnt != '0;

    case (i_reg_addr)
      ADDR_BR: n.rdata = s.br;
      ADDR_CTRL: n.rdata = {s.flag, s.ack_en, s.sta, s.sto, s.wc, s.en, 1'b0, s.ie};
      ADDR_STAT: n.rdata = {s.status, 1'b0, s.ps};
      ADDR_DATA: n.rdata = s.data;
      ADDR_OWN: n.rdata = s.own;
      ADDR_MASK: n.rdata = {s.mask, 1'b0};
      default: n.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      s <= TWC_RST;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_data_wr;
    i_reg_wr && i_reg_addr == ADDR_DATA;
  endsequence

  sequence s_flag_w1c;
    i_reg_wr && i_reg_addr == ADDR_CTRL && i_reg_wdata[CTRL_FLAG] && s.flag && !ev_set;
  endsequence

  property p_irq_level;
    @(posedge i_mclk) disable iff (!i_resetn) s.flag && s.ie && i_global_irq_en |=> o_irq || !s.flag || !s.ie;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised for pending flag");

  property p_irq_off;
    @(posedge i_mclk) disable iff (!i_resetn) $past(!s.flag) && !s.flag |-> !o_irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt raised without flag");

  property p_scl_stretch;
    @(posedge i_mclk) disable iff (!i_resetn) s.flag && s.en |-> !o_scl_oe_n;
  endproperty
  a_scl_stretch: assert property (p_scl_stretch) else $error("clock released while flag set");

  property p_flag_w1c;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_flag_w1c ##0 (s.qcnt != FIFO_DEPTH) |=> !s.flag ##1 (s.st != ST_HOLD || !s.go);
  endproperty
  a_flag_w1c: assert property (p_flag_w1c) else $error("flag write-one clear or launch failed");

  property p_wc_set;
    @(posedge i_mclk) disable iff (!i_resetn)
      s_data_wr and (!s.flag) |=> s.wc && (s.data == $past(s.data) || $past(s.st) inside {ST_HIGH, ST_SLAVE});
  endproperty
  a_wc_set: assert property (p_wc_set) else $error("collision not flagged or data changed");

  property p_wc_clr;
    @(posedge i_mclk) disable iff (!i_resetn) s_data_wr and (s.flag) |=> !s.wc && s.data == $past(i_reg_wdata);
  endproperty
  a_wc_clr: assert property (p_wc_clr) else $error("data write with flag mishandled");

  property p_status_load;
    @(posedge i_mclk) disable iff (!i_resetn) $rose(s.flag) |=> s.status == $past(s.pend) ##1 (s.flag || s.status == SC_NOINFO);
  endproperty
  a_status_load: assert property (p_status_load) else $error("status code not loaded after flag");

  property p_reserved_zero;
    @(posedge i_mclk) disable iff (!i_resetn)
      !($past(i_reg_addr) == ADDR_CTRL && o_reg_rdata[1]) && !($past(i_reg_addr) == ADDR_STAT && o_reg_rdata[2]) &&
      !($past(i_reg_addr) == ADDR_MASK && o_reg_rdata[0]);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read as one");

  property p_disable;
    @(posedge i_mclk) disable iff (!i_resetn) !s.en |-> o_scl_oe_n && o_sda_oe_n && s.st == ST_IDLE && !s.master;
  endproperty
  a_disable: assert property (p_disable) else $error("pins driven while disabled");

  property p_start_wait;
    @(posedge i_mclk) disable iff (!i_resetn) s.st == ST_IDLE && s.busy |=> s.st != ST_START;
  endproperty
  a_start_wait: assert property (p_start_wait) else $error("start issued on busy bus");

endmodule : twc_controller

`default_nettype wire

// ### rtl/twc_pkg.sv
// Constants, status codes, state encoding and state record of the two-wire controller.
// Assumes a byte-wide register port on the processor data bus and a single clock.
package twc_pkg;

  // ----------------------------------------------------------------
  // Register indices on the processor data bus
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_BR = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_STAT = 3'h2;
  localparam logic [2:0] ADDR_DATA = 3'h3;
  localparam logic [2:0] ADDR_OWN = 3'h4;
  localparam logic [2:0] ADDR_MASK = 3'h5;

  // ----------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------
  localparam int CTRL_FLAG = 7;
  localparam int CTRL_ACK = 6;
  localparam int CTRL_STA = 5;
  localparam int CTRL_STO = 4;
  localparam int CTRL_WC = 3;
  localparam int CTRL_EN = 2;
  localparam int CTRL_IE = 0;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] BR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [7:0] OWN_RST = 8'hfe;
  localparam logic [14:0] HALF_BASE = 15'h0008;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  // ----------------------------------------------------------------
  // Status codes
  // ----------------------------------------------------------------
  localparam logic [4:0] SC_START = 5'h01;
  localparam logic [4:0] SC_RSTART = 5'h02;
  localparam logic [4:0] SC_SLAW_ACK = 5'h03;
  localparam logic [4:0] SC_SLAW_NACK = 5'h04;
  localparam logic [4:0] SC_MT_ACK = 5'h05;
  localparam logic [4:0] SC_MT_NACK = 5'h06;
  localparam logic [4:0] SC_ARB = 5'h07;
  localparam logic [4:0] SC_SLAR_ACK = 5'h08;
  localparam logic [4:0] SC_SLAR_NACK = 5'h09;
  localparam logic [4:0] SC_MR_ACK = 5'h0a;
  localparam logic [4:0] SC_MR_NACK = 5'h0b;
  localparam logic [4:0] SC_SR_ADDR = 5'h0c;
  localparam logic [4:0] SC_SR_GC = 5'h0d;
  localparam logic [4:0] SC_SR_ACK = 5'h0e;
  localparam logic [4:0] SC_SR_NACK = 5'h0f;
  localparam logic [4:0] SC_SL_STOP = 5'h10;
  localparam logic [4:0] SC_ST_ADDR = 5'h11;
  localparam logic [4:0] SC_ST_ACK = 5'h12;
  localparam logic [4:0] SC_ST_NACK = 5'h13;
  localparam logic [4:0] SC_NOINFO = 5'h1f;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_HOLD, ST_PRE_LOW, ST_PRE_HIGH, ST_SLAVE
  } twc_st_t;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    twc_st_t st;
    logic [14:0] cnt;
    logic [3:0] bitn;
    logic [7:0] br;
    logic [1:0] ps;
    logic [7:0] own;
    logic [6:0] mask;
    logic [7:0] data;
    logic flag, ack_en, sta, sto, wc, en, ie;
    logic [4:0] status;
    logic [4:0] pend;
    logic busy, master, addressed, tx, addr_ph, rx_ack, arb, gc, go, stopping, rs;
    logic sda_drv, scl_oe_n, sda_oe_n, irq;
    logic [7:0] rdata;
    logic [7:0] q0;
    logic [7:0] q1;
    logic [1:0] qcnt;
    logic rxv;
  } twc_state_t;

  localparam twc_state_t TWC_RST = '{scl_sy: 2'h3, sda_sy: 2'h3, scl_d: 1'b1, sda_d: 1'b1, st: ST_IDLE,
                                     br: BR_RST, data: DATA_RST, own: OWN_RST, status: SC_NOINFO,
                                     pend: SC_NOINFO, scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};

endpackage : twc_pkg
